// File: hw/sleep_ctrl_defines.vh
`ifndef SLEEP_CTRL_DEFINES_VH
`define SLEEP_CTRL_DEFINES_VH
// register offsets (plain port, byte addresses)
`define ADDR_VREG        4'h0
`define ADDR_THROTTLE    4'h1
`define ADDR_PWRSTAT     4'h2
`define ADDR_IRQ_STATUS  4'h3
`define ADDR_IRQ_MASK    4'h4
// regulator control fields
`define VREG_POWER_BIT   1
`define VREG_FIXED_BIT   0
`define VREG_RESET       8'h01
// throttle/idle control fields
`define THR_IDLE_BIT     7
`define THR_EN_BIT       6
`define THR_ROI_BIT      5
`define THR_DOE_BIT      4
`define THR_RATIO_HI     2
`define THR_RATIO_LO     0
`define THR_RESET        8'h00
// power status fields
`define STAT_TO_BIT      1
`define STAT_PD_BIT      0
// interrupt status bits
`define IRQ_WAKE_BIT     0
`define IRQ_NOP_BIT      1
`define IRQ_WDT_BIT      2
`define IRQ_WIDTH        3
// timing
`define OST_OSC_PERIODS  16'h0400
`define REG_SETTLE_NS    1000
`define CLK_PERIOD_NS    10
// clock modes
`define CLKMODE_CRYSTAL  2'h0
`define CLKMODE_EXT      2'h1
`define CLKMODE_INTERNAL_OSCILLATOR_MODE   2'h2
// vector
`define IRQ_VECTOR       16'h0004
`endif

// File: hw/throttle_strobe.v
`timescale 1ns/1ns
`include "sleep_ctrl_defines.vh"
module throttle_strobe (
  // clock and reset
  input  wire       clk_in,
  input  wire       rst_n_in,
  // control
  input  wire       periph_tick_in,
  input  wire       active_in,
  input  wire [2:0] ratio_in,
  // result
  output reg        cpu_enable_out
);
  reg  [7:0] count_reg;
  reg        active_d_reg;
  wire [7:0] last_count;

  // modulo 2^(ratio+1)
  assign last_count = (8'h02 << ratio_in) - 8'h01;

  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      count_reg      <= 8'h00;
      active_d_reg   <= 1'b0;
      cpu_enable_out <= 1'b0;
    end else begin
      active_d_reg <= active_in;
      if (active_in != active_d_reg) begin
        count_reg <= 8'h00;
      end else if (periph_tick_in) begin
        count_reg <= (count_reg >= last_count) ? 8'h00 : count_reg + 8'h01;
      end
      // one cycle of N, rest idle
      cpu_enable_out <= periph_tick_in & (!active_in | (count_reg == 8'h00));
    end
  end
endmodule // throttle_strobe

// File: hw/sleep_idle_doze_control.v
`timescale 1ns/1ns
`include "sleep_ctrl_defines.vh"
// Function
// - masked pending irq before sleep makes sleep a no-op, flags and watchdog untouched.
// - irq during/after sleep completes sleep, wakes, clears watchdog, sets TO, clears PD.
// - crystal mode wake waits 1024 oscillator periods; external and internal clock skip it.
// - interrupt wake with global enable vectors to 0004h, otherwise continues after sleep.
// - regulator low-power select lowers regulator in sleep and adds wake settle delay.
// - regulator control bit 0 reads one; software keeps it set.
// - idle select stops only cpu clock on sleep; else full sleep stops clocks.
// - throttle enable runs cpu at throttle ratio rate; clear means full speed.
// - recover-on-irq clears throttle enable on interrupt entry.
// - throttle-on-return sets throttle enable on return-from-interrupt.
// - ratio code n gives one cpu cycle per 2^(n+1) peripheral cycles.
// - debug forces full speed without changing stored throttle enable.
// - throttled cpu runs one cycle then idles N-1; peripherals keep running.
// - any interrupt ends idle even with global enable clear; idle select kept.
// - watchdog timeout in idle wakes, not resets; throttle enable untouched.
module sleep_idle_doze_control #(
  parameter OST_CYCLES    = `OST_OSC_PERIODS,
  parameter SETTLE_CYCLES = (`REG_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
  // clock and reset
  input  wire        SYS_CLK_IN,
  input  wire        RESET_N_IN,
  input  wire        POR_BOR_IN,
  // cpu core
  input  wire        PERIPH_TICK_IN,
  input  wire        SLEEP_EXEC_IN,
  input  wire        IRQ_ENTRY_IN,
  input  wire        RETURN_FROM_IRQ_IN,
  input  wire        GLOBAL_IRQ_ENABLE_IN,
  input  wire        IRQ_PENDING_IN,
  input  wire        IN_CIRCUIT_DEBUG_IN,
  input  wire [1:0]  CLOCK_MODE_IN,
  input  wire        OSC_TICK_IN,
  // watchdog
  input  wire        WDT_TIMEOUT_IN,
  output reg         WDT_CLEAR_OUT,
  // register port
  input  wire [3:0]  ADDR_IN,
  input  wire [7:0]  WDATA_IN,
  input  wire        WR_IN,
  input  wire        RD_IN,
  output reg  [7:0]  RDATA_OUT,
  // power state
  output wire        CPU_ENABLE_OUT,
  output reg         CPU_CLOCK_STOP_OUT,
  output reg         SYS_CLOCK_STOP_OUT,
  output reg         REG_LOW_POWER_OUT,
  output reg         VECTOR_TAKE_OUT,
  output reg  [15:0] VECTOR_ADDR_OUT,
  output reg         TIMEOUT_FLAG_OUT,
  output reg         POWERDOWN_FLAG_OUT,
  output wire        IRQ_OUT
);
  localparam ST_RUN   = 3'h0;
  localparam ST_SLEEP = 3'h1;
  localparam ST_IDLE  = 3'h2;
  localparam ST_OST   = 3'h3;
  localparam ST_SETTL = 3'h4;

  reg        rst_s1_reg;
  reg        rst_s2_reg;
  wire       rst_n;
  reg        por_s1_reg;
  reg        por_s2_reg;
  reg  [2:0] state_reg;
  reg  [2:0] state_next;
  reg        regulator_sleep_power_select_reg;
  reg        idle_on_sleep_select_reg;
  reg        throttle_enable_reg;
  reg        recover_on_irq_reg;
  reg        throttle_on_return_reg;
  reg  [2:0] throttle_ratio_reg;
  reg  [`IRQ_WIDTH-1:0] irq_status_reg;
  reg  [`IRQ_WIDTH-1:0] irq_mask_reg;
  reg  [`IRQ_WIDTH-1:0] irq_set;
  reg  [15:0] wait_count_reg;
  reg        wake_irq_reg;
  reg        go_wake;
  reg        go_nop;
  wire       throttle_active;
  wire       wr_vreg;
  wire       wr_throttle;
  wire       wr_status;
  wire       wr_mask;

  // reset release through two flops
  always @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      rst_s1_reg <= 1'b0;
      rst_s2_reg <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_s2_reg <= rst_s1_reg;
    end
  end
  assign rst_n = rst_s2_reg;

  // no reset here: the strap must be seen while reset is still held
  always @(posedge SYS_CLK_IN) begin
    por_s1_reg <= POR_BOR_IN;
    por_s2_reg <= por_s1_reg;
  end

  // debug override leaves stored enable alone
  assign throttle_active = throttle_enable_reg & ~IN_CIRCUIT_DEBUG_IN;

  // one strobe-and-address match shared by every register write
  function wr_hit;
    input [3:0] addr;
    input [3:0] target;
    input       strobe;
    begin
      wr_hit = strobe & (addr == target);
    end
  endfunction

  assign wr_vreg     = wr_hit(ADDR_IN, `ADDR_VREG, WR_IN);
  assign wr_throttle = wr_hit(ADDR_IN, `ADDR_THROTTLE, WR_IN);
  assign wr_status   = wr_hit(ADDR_IN, `ADDR_IRQ_STATUS, WR_IN);
  assign wr_mask     = wr_hit(ADDR_IN, `ADDR_IRQ_MASK, WR_IN);

  throttle_strobe u_strobe (
    .clk_in         (SYS_CLK_IN),
    .rst_n_in       (rst_n),
    .periph_tick_in (PERIPH_TICK_IN & (state_reg == ST_RUN)),
    .active_in      (throttle_active),
    .ratio_in       (throttle_ratio_reg),
    .cpu_enable_out (CPU_ENABLE_OUT)
  );

  function [2:0] wake_target;
    input       crystal;
    input       low_power;
    begin
      if (crystal)
        wake_target = ST_OST;
      else if (low_power)
        wake_target = ST_SETTL;
      else
        wake_target = ST_RUN;
    end
  endfunction

  always @* begin
    state_next = state_reg;
    go_wake    = 1'b0;
    go_nop     = 1'b0;
    case (state_reg)
      ST_RUN: begin
        if (SLEEP_EXEC_IN) begin
          if (IRQ_PENDING_IN && !GLOBAL_IRQ_ENABLE_IN) begin
            go_nop = 1'b1;
          end else if (idle_on_sleep_select_reg) begin
            state_next = ST_IDLE;
          end else begin
            state_next = ST_SLEEP;
          end
        end
      end
      ST_SLEEP: begin
        if (IRQ_PENDING_IN || WDT_TIMEOUT_IN) begin
          go_wake    = 1'b1;
          state_next = wake_target(CLOCK_MODE_IN == `CLKMODE_CRYSTAL, regulator_sleep_power_select_reg);
        end
      end
      ST_IDLE: begin
        // clocks keep running so no start-up wait
        if (IRQ_PENDING_IN || WDT_TIMEOUT_IN) begin
          go_wake    = 1'b1;
          state_next = ST_RUN;
        end
      end
      ST_OST: begin
        if (wait_count_reg == 16'h0000)
          state_next = regulator_sleep_power_select_reg ? ST_SETTL : ST_RUN;
      end
      ST_SETTL: begin
        if (wait_count_reg == 16'h0000)
          state_next = ST_RUN;
      end
      default: state_next = ST_RUN;
    endcase
  end

  always @* begin
    irq_set = {`IRQ_WIDTH{1'b0}};
    irq_set[`IRQ_WAKE_BIT] = go_wake;
    irq_set[`IRQ_NOP_BIT]  = go_nop;
    irq_set[`IRQ_WDT_BIT]  = go_wake & WDT_TIMEOUT_IN & ~IRQ_PENDING_IN;
  end

  always @(posedge SYS_CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      state_reg          <= ST_RUN;
      wait_count_reg     <= 16'h0000;
      wake_irq_reg       <= 1'b0;
      WDT_CLEAR_OUT      <= 1'b0;
      CPU_CLOCK_STOP_OUT <= 1'b0;
      SYS_CLOCK_STOP_OUT <= 1'b0;
      REG_LOW_POWER_OUT  <= 1'b0;
      VECTOR_TAKE_OUT    <= 1'b0;
      VECTOR_ADDR_OUT    <= 16'h0000;
      TIMEOUT_FLAG_OUT   <= 1'b1;
      POWERDOWN_FLAG_OUT <= 1'b1;
    end else begin
      state_reg       <= state_next;
      VECTOR_TAKE_OUT <= 1'b0;
      WDT_CLEAR_OUT   <= 1'b0;
      if (state_reg == ST_RUN && SLEEP_EXEC_IN && !go_nop) begin
        WDT_CLEAR_OUT      <= 1'b1;
        TIMEOUT_FLAG_OUT   <= 1'b1;
        POWERDOWN_FLAG_OUT <= 1'b0;
      end
      if (go_wake) begin
        WDT_CLEAR_OUT <= 1'b1;
        wake_irq_reg  <= IRQ_PENDING_IN;
        if (!IRQ_PENDING_IN)
          TIMEOUT_FLAG_OUT <= 1'b0;
      end
      // watchdog held clear while the oscillator starts
      if (state_reg == ST_OST)
        WDT_CLEAR_OUT <= 1'b1;
      if (state_next == ST_OST && state_reg != ST_OST)
        wait_count_reg <= OST_CYCLES[15:0];
      else if (state_next == ST_SETTL && state_reg != ST_SETTL)
        wait_count_reg <= SETTLE_CYCLES[15:0];
      else if (state_reg == ST_OST && OSC_TICK_IN && wait_count_reg != 16'h0000)
        wait_count_reg <= wait_count_reg - 16'h0001;
      else if (state_reg == ST_SETTL && wait_count_reg != 16'h0000)
        wait_count_reg <= wait_count_reg - 16'h0001;
      if (state_reg != ST_RUN && state_next == ST_RUN && (go_wake ? IRQ_PENDING_IN : wake_irq_reg)) begin
        VECTOR_TAKE_OUT <= GLOBAL_IRQ_ENABLE_IN;
        VECTOR_ADDR_OUT <= `IRQ_VECTOR;
      end
      CPU_CLOCK_STOP_OUT <= (state_next != ST_RUN);
      SYS_CLOCK_STOP_OUT <= (state_next == ST_SLEEP);
      REG_LOW_POWER_OUT  <= (state_next == ST_SLEEP) & regulator_sleep_power_select_reg;
    end
  end

  // control registers
  always @(posedge SYS_CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      regulator_sleep_power_select_reg <= 1'b0;
      throttle_enable_reg    <= 1'b0;
      recover_on_irq_reg     <= 1'b0;
      throttle_on_return_reg <= 1'b0;
      throttle_ratio_reg     <= 3'h0;
      irq_status_reg         <= {`IRQ_WIDTH{1'b0}};
      irq_mask_reg           <= {`IRQ_WIDTH{1'b0}};
    end else begin
      if (wr_vreg)
        regulator_sleep_power_select_reg <= WDATA_IN[`VREG_POWER_BIT];
      if (wr_throttle) begin
        throttle_enable_reg    <= WDATA_IN[`THR_EN_BIT];
        recover_on_irq_reg     <= WDATA_IN[`THR_ROI_BIT];
        throttle_on_return_reg <= WDATA_IN[`THR_DOE_BIT];
        throttle_ratio_reg     <= WDATA_IN[`THR_RATIO_HI:`THR_RATIO_LO];
      end
      // hardware changes win over a same-cycle write
      if (IRQ_ENTRY_IN && recover_on_irq_reg)
        throttle_enable_reg <= 1'b0;
      else if (RETURN_FROM_IRQ_IN && throttle_on_return_reg)
        throttle_enable_reg <= 1'b1;
      if (wr_mask)
        irq_mask_reg <= WDATA_IN[`IRQ_WIDTH-1:0];
      if (wr_status)
        irq_status_reg <= (irq_status_reg & ~WDATA_IN[`IRQ_WIDTH-1:0]) | irq_set;
      else
        irq_status_reg <= irq_status_reg | irq_set;
    end
  end

  // idle select survives all but power-on/brown-out
  always @(posedge SYS_CLK_IN) begin
    if (!rst_n && por_s2_reg)
      idle_on_sleep_select_reg <= 1'b0;
    else if (rst_n && wr_throttle)
      idle_on_sleep_select_reg <= WDATA_IN[`THR_IDLE_BIT];
  end

  assign IRQ_OUT = |(irq_status_reg & irq_mask_reg);

  always @(posedge SYS_CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      RDATA_OUT <= 8'h00;
    end else if (RD_IN) begin
      case (ADDR_IN)
        `ADDR_VREG:       RDATA_OUT <= {6'h00, regulator_sleep_power_select_reg, 1'b1};
        `ADDR_THROTTLE:   RDATA_OUT <= {idle_on_sleep_select_reg, throttle_enable_reg, recover_on_irq_reg,
                                        throttle_on_return_reg, 1'b0, throttle_ratio_reg};
        `ADDR_PWRSTAT:    RDATA_OUT <= {6'h00, TIMEOUT_FLAG_OUT, POWERDOWN_FLAG_OUT};
        `ADDR_IRQ_STATUS: RDATA_OUT <= {5'h00, irq_status_reg};
        `ADDR_IRQ_MASK:   RDATA_OUT <= {5'h00, irq_mask_reg};
        default:          RDATA_OUT <= 8'h00;
      endcase
    end else begin
      RDATA_OUT <= 8'h00;
    end
  end
endmodule // sleep_idle_doze_control

// File: verif/sleep_idle_doze_control_checker.sv
`timescale 1ns/1ns
module sleep_idle_doze_control_checker (
  // clock and reset
  input wire        SYS_CLK_IN,
  input wire        RESET_N_IN,
  // cpu and bus
  input wire        SLEEP_EXEC_IN,
  input wire        IRQ_PENDING_IN,
  input wire        GLOBAL_IRQ_ENABLE_IN,
  input wire        RD_IN,
  // outputs watched
  input wire        WDT_CLEAR_OUT,
  input wire [7:0]  RDATA_OUT,
  input wire        CPU_ENABLE_OUT,
  input wire        CPU_CLOCK_STOP_OUT,
  input wire        SYS_CLOCK_STOP_OUT,
  input wire        REG_LOW_POWER_OUT,
  input wire        VECTOR_TAKE_OUT,
  input wire [15:0] VECTOR_ADDR_OUT,
  input wire        TIMEOUT_FLAG_OUT,
  input wire        POWERDOWN_FLAG_OUT
);
  default clocking cb @(posedge SYS_CLK_IN); endclocking
  default disable iff (!RESET_N_IN);
  sequence s_nop; SLEEP_EXEC_IN && !CPU_CLOCK_STOP_OUT && IRQ_PENDING_IN && !GLOBAL_IRQ_ENABLE_IN; endsequence
  sequence s_go; SLEEP_EXEC_IN && !CPU_CLOCK_STOP_OUT && !(IRQ_PENDING_IN && !GLOBAL_IRQ_ENABLE_IN); endsequence
  sequence s_in; WDT_CLEAR_OUT && TIMEOUT_FLAG_OUT && !POWERDOWN_FLAG_OUT && CPU_CLOCK_STOP_OUT; endsequence
  sequence s_kept; !WDT_CLEAR_OUT && !CPU_CLOCK_STOP_OUT && $stable(TIMEOUT_FLAG_OUT) && $stable(POWERDOWN_FLAG_OUT); endsequence
  a_nop_flags_kept: assert property (s_nop |=> s_kept) else $error("nop changed state");
  a_sleep_entry_flags: assert property (s_go |=> s_in) else $error("sleep entry wrong");
  // full sleep only: settle and idle look alike at the pins, and settle never wakes
  a_wake_clears_wdt: assert property (IRQ_PENDING_IN && SYS_CLOCK_STOP_OUT |=> WDT_CLEAR_OUT)
    else $error("no wdt clear on wake");
  a_vector_on_run: assert property (VECTOR_TAKE_OUT |-> VECTOR_ADDR_OUT == 16'h0004 && $fell(CPU_CLOCK_STOP_OUT))
    else $error("bad vector");
  a_low_power_sleep: assert property (REG_LOW_POWER_OUT |-> SYS_CLOCK_STOP_OUT) else $error("lp outside sleep");
  a_sys_stop_cpu: assert property (SYS_CLOCK_STOP_OUT |-> CPU_CLOCK_STOP_OUT) else $error("cpu runs in sleep");
  a_stopped_no_exec: assert property (CPU_CLOCK_STOP_OUT [*2] |-> !CPU_ENABLE_OUT) else $error("exec while stopped");
  a_rdata_idle_zero: assert property (!RD_IN |=> RDATA_OUT == 8'h00) else $error("read data not zero");
endmodule // sleep_idle_doze_control_checker

bind sleep_idle_doze_control sleep_idle_doze_control_checker u_chk (
  .SYS_CLK_IN(SYS_CLK_IN), .RESET_N_IN(RESET_N_IN), .SLEEP_EXEC_IN(SLEEP_EXEC_IN),
  .IRQ_PENDING_IN(IRQ_PENDING_IN), .GLOBAL_IRQ_ENABLE_IN(GLOBAL_IRQ_ENABLE_IN), .RD_IN(RD_IN),
  .WDT_CLEAR_OUT(WDT_CLEAR_OUT), .RDATA_OUT(RDATA_OUT), .CPU_ENABLE_OUT(CPU_ENABLE_OUT),
  .CPU_CLOCK_STOP_OUT(CPU_CLOCK_STOP_OUT), .SYS_CLOCK_STOP_OUT(SYS_CLOCK_STOP_OUT),
  .REG_LOW_POWER_OUT(REG_LOW_POWER_OUT), .VECTOR_TAKE_OUT(VECTOR_TAKE_OUT), .VECTOR_ADDR_OUT(VECTOR_ADDR_OUT),
  .TIMEOUT_FLAG_OUT(TIMEOUT_FLAG_OUT), .POWERDOWN_FLAG_OUT(POWERDOWN_FLAG_OUT));

// File: verif/cpu_core_partner.sv
`timescale 1ns/1ns
module cpu_core_partner (
  // clock and reset
  input  wire clk_in,
  input  wire rst_n_in,
  // watchdog control
  input  wire wdt_kick_in,
  input  wire wdt_clear_in,
  // to the block
  output reg  periph_tick_out,
  output reg  osc_tick_out,
  output reg  wdt_timeout_out
);
  // oscillator at half rate so the start-up count stands apart from clock cycles
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      periph_tick_out <= 1'b0;
      osc_tick_out    <= 1'b0;
      wdt_timeout_out <= 1'b0;
    end else begin
      periph_tick_out <= 1'b1;
      osc_tick_out    <= ~osc_tick_out;
      // time-out stands until the block clears the watchdog
      if (wdt_clear_in)
        wdt_timeout_out <= 1'b0;
      else if (wdt_kick_in)
        wdt_timeout_out <= 1'b1;
    end
  end
endmodule // cpu_core_partner

// File: verif/sleep_idle_doze_control_tb_top.sv
`timescale 1ns/1ns
module sleep_idle_doze_control_tb_top;
  localparam int OST = 8;
  localparam int SET = 4;
  reg         clk, rst_n, por, slp, ent, ret, global_interrupt_enable, pend, in_circuit_debug, kick, wr, rd, vseen;
  reg  [1:0]  mode;
  reg  [3:0]  addr;
  reg  [7:0]  wd;
  reg  [2:0]  r;
  wire        tick, otick, wto, wclr, en, cstop, sstop, lp, vtake, irq, tflag, pflag;
  wire [7:0]  rdat;
  wire [15:0] vaddr;
  int         n_mismatch = 0;
  int         checks = 0;
  int         cyc = 0;
  int         n, i;

  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end

  cpu_core_partner pm (.clk_in(clk), .rst_n_in(rst_n), .wdt_kick_in(kick), .wdt_clear_in(wclr),
    .periph_tick_out(tick), .osc_tick_out(otick), .wdt_timeout_out(wto));
  sleep_idle_doze_control #(.OST_CYCLES(OST), .SETTLE_CYCLES(SET)) uut (
    .SYS_CLK_IN(clk), .RESET_N_IN(rst_n), .POR_BOR_IN(por), .PERIPH_TICK_IN(tick),
    .SLEEP_EXEC_IN(slp), .IRQ_ENTRY_IN(ent), .RETURN_FROM_IRQ_IN(ret), .GLOBAL_IRQ_ENABLE_IN(global_interrupt_enable),
    .IRQ_PENDING_IN(pend), .IN_CIRCUIT_DEBUG_IN(in_circuit_debug), .CLOCK_MODE_IN(mode), .OSC_TICK_IN(otick),
    .WDT_TIMEOUT_IN(wto), .WDT_CLEAR_OUT(wclr), .ADDR_IN(addr), .WDATA_IN(wd), .WR_IN(wr), .RD_IN(rd),
    .RDATA_OUT(rdat), .CPU_ENABLE_OUT(en), .CPU_CLOCK_STOP_OUT(cstop), .SYS_CLOCK_STOP_OUT(sstop),
    .REG_LOW_POWER_OUT(lp), .VECTOR_TAKE_OUT(vtake), .VECTOR_ADDR_OUT(vaddr), .TIMEOUT_FLAG_OUT(tflag),
    .POWERDOWN_FLAG_OUT(pflag), .IRQ_OUT(irq));

  // the vector pulse stands one cycle, so it is latched here
  always @(negedge clk)
    if (vtake === 1'b1)
      vseen = 1;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      results;
    end
  end

  function int exp_gap(input [2:0] c);
    return 2 << c;
  endfunction
  function int wake_min;
    return 2 * OST + SET - 2;
  endfunction

  task results;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input string s, input [15:0] e, input [15:0] g);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", s, e, g);
    end
  endtask
  task wr_t(input [3:0] a, input [7:0] v);
    @(posedge clk);
    addr <= a;
    wd <= v;
    wr <= 1;
    @(posedge clk);
    wr <= 0;
  endtask
  task rchk(input string s, input [3:0] a, input [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1;
    @(posedge clk);
    rd <= 0;
    @(negedge clk);
    chk(s, e, rdat);
  endtask
  task pulse(input int k);
    @(posedge clk);
    slp <= (k == 0);
    ent <= (k == 1);
    ret <= (k == 2);
    @(posedge clk);
    {slp, ent, ret} <= 3'h0;
    @(negedge clk);
  endtask
  task rst_t(input bit p);
    @(posedge clk);
    rst_n <= 0;
    por <= p;
    repeat (10) @(posedge clk);
    rst_n <= 1;
    por <= 0;
    repeat (3) @(posedge clk);
  endtask
  task gap;
    repeat (3) @(negedge clk); // skip the counter restart after a throttle change
    for (n = 0; en !== 1'b1 && n < 600; n++)
      @(negedge clk);
    @(negedge clk);
    for (n = 1; en !== 1'b1 && n < 600; n++)
      @(negedge clk);
  endtask
  // counts cycles from the wake cause until the cpu clock runs again
  task wake(input bit w);
    @(posedge clk);
    kick <= w;
    pend <= !w;
    @(posedge clk);
    kick <= 0;
    @(negedge clk);
    for (n = 1; cstop !== 1'b0 && n < 200; n++)
      @(negedge clk);
    @(posedge clk);
    pend <= 0;
  endtask
  task recover_on_irq(input [7:0] v, input int k, input [7:0] e);
    wr_t(4'h1, v);
    pulse(k);
    rchk("hw_thr", 4'h1, e);
  endtask

  initial begin
    {rst_n, slp, ent, ret, global_interrupt_enable, pend, in_circuit_debug, kick, wr, rd, vseen} = '0;
    {addr, wd, mode} = '0;
    por = 1;
    n = $urandom(5);
    rst_t(1'b1);
    rchk("vreg", 4'h0, 8'h01);
    rchk("thr", 4'h1, 8'h00);
    rchk("stat", 4'h2, 8'h03);
    rchk("unmap", 4'hF, 8'h00);
    wr_t(4'h0, 8'h03);
    rchk("vreg_lp", 4'h0, 8'h03);
    wr_t(4'h4, 8'h02);
    pend <= 1;
    pulse(0);
    chk("nop_stop", 0, cstop);
    rchk("nop_stat", 4'h2, 8'h03);
    chk("nop_pins", 16'h0003, {tflag, pflag});
    rchk("irq_stat", 4'h3, 8'h02);
    chk("irq_on", 1, irq);
    wr_t(4'h3, 8'h02);
    pend <= 0;
    @(negedge clk);
    chk("irq_off", 0, irq);
    for (i = 0; i < 8; i++) begin
      wr_t(4'h1, 8'h40 | i[7:0]);
      gap;
      chk("gap", exp_gap(i[2:0]), n);
    end
    @(posedge clk);
    in_circuit_debug <= 1;
    gap;
    chk("dbg_gap", 1, n);
    @(posedge clk);
    in_circuit_debug <= 0;
    rchk("dbg_keep", 4'h1, 8'h47);
    wr_t(4'h1, 8'h07);
    gap;
    chk("full_gap", 1, n);
    r = $urandom;
    recover_on_irq(8'h60 | r, 1, 8'h20 | r);
    recover_on_irq(8'h40 | r, 1, 8'h40 | r);
    recover_on_irq(8'h10 | r, 2, 8'h50 | r);
    recover_on_irq(8'h00 | r, 2, 8'h00 | r);
    wr_t(4'h1, 8'h00);
    for (i = 1; i < 3; i++) begin
      @(posedge clk);
      mode <= i[1:0];
      global_interrupt_enable <= (i == 1);
      vseen = 0;
      pulse(0);
      chk("sys_stop", 1, sstop);
      chk("lp", 1, lp);
      rchk("slp_stat", 4'h2, 8'h02);
      chk("slp_pins", 16'h0002, {tflag, pflag});
      wake(0);
      chk("fast", 1, n >= SET && n <= SET + 4);
      chk("vec", i == 1, vseen);
      chk("vaddr", 16'h0004, vaddr);
    end
    @(posedge clk);
    mode <= 2'h0;
    pulse(0);
    wake(0);
    chk("ost", 1, n >= wake_min() && n <= wake_min() + 8);
    wr_t(4'h0, 8'h01);
    pulse(0);
    chk("lp_off", 0, lp);
    wake(0);
    chk("ost_only", 1, n >= 2 * OST && n <= 2 * OST + 4);
    wr_t(4'h1, 8'hE0);
    global_interrupt_enable <= 0;
    pulse(0);
    chk("idle_sys", 0, sstop);
    chk("idle_cpu", 1, cstop);
    wake(1);
    chk("wdt_wake", 1, n <= 4);
    rchk("wdt_thr", 4'h1, 8'hE0);
    rchk("wdt_stat", 4'h2, 8'h00);
    pulse(0);
    chk("idle_again", 1, cstop & ~sstop);
    wake(0);
    chk("irq_idle", 1, n <= 4);
    rst_t(1'b0);
    rchk("warm", 4'h1, 8'h80);
    results;
  end
endmodule // sleep_idle_doze_control_tb_top
